/* File: scfg_pkg.sv */
// Purpose: Shared constants and types for the system configuration block
// Assumes: 32-bit APB data, 8-bit registers in the low byte of a word
// Notes:   Every offset, bit position and register field reset value lives here
package scfg_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFF_CONFIG_TWO  = 12'h0d8;
    localparam logic [11:0] OFF_CONFIG_ONE  = 12'h0e8;

    // ------------------------------------------------------------
    // Field positions, first register
    // ------------------------------------------------------------
    localparam int C1_TWOWIRE   = 6;
    localparam int C1_RANDOM    = 5;
    localparam int C1_TXECHO    = 4;
    localparam int C1_READVALID = 2;
    localparam int C1_INITPEND  = 1;
    localparam int C1_TIMEREN   = 0;

    // ------------------------------------------------------------
    // Field positions, second register
    // ------------------------------------------------------------
    localparam int C2_GENCALL   = 6;
    localparam int C2_RAMOFF    = 4;
    localparam int C2_RESV_ONE  = 3;
    localparam int C2_WDRESTART = 1;
    localparam int C2_SWRESET   = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CONFIG_ONE = 8'h00;
    localparam logic [7:0]  RST_CONFIG_TWO = 8'h18;
    localparam logic        RST_RAMOFF     = 1'h1;
    localparam logic        RST_RESV_ONE   = 1'h1;
    localparam logic [31:0] RST_PRDATA     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Operating modes as reported by the mode straps
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCFG_MODE_TEST   = 2'h0,
        SCFG_MODE_DEBUG  = 2'h1,
        SCFG_MODE_PROG   = 2'h2,
        SCFG_MODE_NORMAL = 2'h3
    } scfg_mode_e;

    // ------------------------------------------------------------
    // Port pin indices
    // ------------------------------------------------------------
    localparam int PIN_SCL  = 0;
    localparam int PIN_SDA  = 1;
    localparam int PIN_ECHO = 2;
    localparam int NUM_PINS = 3;

    // ------------------------------------------------------------
    // Bundles and state
    // ------------------------------------------------------------
    // Port driver bundle; oeN low means the pin is driven
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oeN;
    } scfg_pins_s;

    // Two-wire controller pad bundle
    typedef struct packed {
        logic sclOut;
        logic sclOeN;
        logic sdaOut;
        logic sdaOeN;
    } scfg_twi_s;

    typedef struct packed {
        logic        twoWire;
        logic        genCall;
        logic        randStart;
        logic        txEcho;
        logic        readValid;
        logic        initPend;
        logic        timerEn;
        logic        ramOff;
        logic        wdRestart;
        logic        swReset;
        logic        timerRun;
        logic        paAuto;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } scfg_state_s;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        scfg_pins_s pins;
        logic [2:0] gpioIn;
        logic       sclIn;
        logic       sdaIn;
    } scfg_mux_s;

endpackage

/* File: scfg_pin_mux.sv */
// Purpose: Port pin routing between plain I/O, two-wire bus and tx echo
// Assumes: Pin levels arrive asynchronously; controller signals are on clk
// Notes:   Pad outputs are registered, so routing adds one cycle
`timescale 1ns/10ps

module scfg_pin_mux (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               twowirePinSelect,
    input  wire logic               txEchoEnable,
    input  wire scfg_pkg::scfg_pins_s gpioDrive,
    input  wire scfg_pkg::scfg_twi_s  twiDrive,
    input  wire logic               txData,
    input  wire logic [2:0]         pinIn,
    output      scfg_pkg::scfg_pins_s pinDrive,
    output      logic [2:0]         gpioIn,
    output      logic               twiSclIn,
    output      logic               twiSdaIn
);

    scfg_pkg::scfg_mux_s st_ff;
    scfg_pkg::scfg_mux_s nxt_st;

    // ------------------------------------------------------------
    // Routing
    // ------------------------------------------------------------
    always_comb begin
        nxt_st       = st_ff;
        // Only the second stage is read beyond the synchroniser
        nxt_st.sync1 = pinIn;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.pins  = gpioDrive;
        nxt_st.gpioIn = st_ff.sync2;
        // Idle bus lines read high when the pins are not routed
        nxt_st.sclIn = 1'h1;
        nxt_st.sdaIn = 1'h1;
        if (twowirePinSelect) begin
            nxt_st.pins.out[scfg_pkg::PIN_SCL] = twiDrive.sclOut;
            nxt_st.pins.oeN[scfg_pkg::PIN_SCL] = twiDrive.sclOeN;
            nxt_st.pins.out[scfg_pkg::PIN_SDA] = twiDrive.sdaOut;
            nxt_st.pins.oeN[scfg_pkg::PIN_SDA] = twiDrive.sdaOeN;
            nxt_st.sclIn = st_ff.sync2[scfg_pkg::PIN_SCL];
            nxt_st.sdaIn = st_ff.sync2[scfg_pkg::PIN_SDA];
        end
        if (txEchoEnable) begin
            nxt_st.pins.out[scfg_pkg::PIN_ECHO] = txData;
            nxt_st.pins.oeN[scfg_pkg::PIN_ECHO] = 1'h0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '{sync1: 3'h7, sync2: 3'h7,
                       pins: '{out: 3'h0, oeN: 3'h7},
                       gpioIn: 3'h7, sclIn: 1'h1, sdaIn: 1'h1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pinDrive = st_ff.pins;
    assign gpioIn   = st_ff.gpioIn;
    assign twiSclIn = st_ff.sclIn;
    assign twiSdaIn = st_ff.sdaIn;

endmodule // scfg_pin_mux

/* File: scfg_regs.sv */
// Purpose: System configuration registers behind an APB slave
// Assumes: Status and done pulses come from logic on clk
// Notes:   Wakeup is a one-cycle pulse that keeps a few bits; sys_rst
//          restores every reset value
//
// The APB slave port was decided locally.
`timescale 1ns/10ps

// Functional notes
// - The two-wire select bit routes the two shared pins to the bus.
// - Writing 1 to random start holds it until the number is ready.
// - Echo enable puts tx data on the echo pin and stops auto PA on.
// - The read-valid bit reads 1 only while a period read is trusted.
// - A period write sets the init flag until the new period applies.
// - The timer runs always in normal mode, else as its enable says.
// - The general call enable bit lets the bus answer general calls.
// - Lower RAM power-off bit resets to 1; 1 removes retention power.
// - Writing 1 to watchdog restart holds it until the counter clears.
// - Writing 1 to software reset holds it until that reset is done.
module scfg_regs (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output      logic               pready,
    output      logic [31:0]        prdata,
    output      logic               pslverr,
    // System side
    input  wire logic               wakeupPulse,
    input  wire logic [1:0]         opMode,
    input  wire logic               randomDone,
    input  wire logic               watchdogDone,
    input  wire logic               swResetDone,
    input  wire logic               periodWritten,
    input  wire logic               periodApplied,
    input  wire logic               periodReadCorrupt,
    output      logic               randomStart,
    output      logic               watchdogRestart,
    output      logic               swResetRequest,
    output      logic               timerRun,
    output      logic               powerAmpAutoEnable,
    output      logic               generalCallEnable,
    output      logic               lowerRamPowerOff,
    output      logic               twowirePinSelect,
    output      logic               txEchoEnable,
    // Pins
    input  wire scfg_pkg::scfg_pins_s gpioDrive,
    input  wire scfg_pkg::scfg_twi_s  twiDrive,
    input  wire logic               txData,
    input  wire logic [2:0]         pinIn,
    output      scfg_pkg::scfg_pins_s pinDrive,
    output      logic [2:0]         gpioIn,
    output      logic               twiSclIn,
    output      logic               twiSdaIn
);

    scfg_pkg::scfg_state_s st_ff;
    scfg_pkg::scfg_state_s nxt_st;

    logic       setup;
    logic       access;
    logic       hitOne;
    logic       hitTwo;
    logic       wrByte;
    logic [7:0] wd;
    logic [7:0] rdOne;
    logic [7:0] rdTwo;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign setup  = psel && !penable;
    assign access = psel && penable && st_ff.pready;
    assign hitOne = (paddr == scfg_pkg::OFF_CONFIG_ONE);
    assign hitTwo = (paddr == scfg_pkg::OFF_CONFIG_TWO);
    // Registers are one byte wide, so only lane 0 can change them
    assign wrByte = access && pwrite && pstrb[0];
    assign wd     = pwdata[7:0];

    // ------------------------------------------------------------
    // Read views; reserved and unused bits read 0 except bit 3 of two
    // ------------------------------------------------------------
    always_comb begin
        rdOne = 8'h00;
        rdOne[scfg_pkg::C1_TWOWIRE]   = st_ff.twoWire;
        rdOne[scfg_pkg::C1_RANDOM]    = st_ff.randStart;
        rdOne[scfg_pkg::C1_TXECHO]    = st_ff.txEcho;
        rdOne[scfg_pkg::C1_READVALID] = st_ff.readValid;
        rdOne[scfg_pkg::C1_INITPEND]  = st_ff.initPend;
        rdOne[scfg_pkg::C1_TIMEREN]   = st_ff.timerEn;
        rdTwo = 8'h00;
        rdTwo[scfg_pkg::C2_GENCALL]   = st_ff.genCall;
        rdTwo[scfg_pkg::C2_RAMOFF]    = st_ff.ramOff;
        rdTwo[scfg_pkg::C2_RESV_ONE]  = scfg_pkg::RST_RESV_ONE;
        rdTwo[scfg_pkg::C2_WDRESTART] = st_ff.wdRestart;
        rdTwo[scfg_pkg::C2_SWRESET]   = st_ff.swReset;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        // Bus handshake: one wait-free access phase per transfer
        nxt_st.pready  = setup;
        nxt_st.pslverr = setup && !(hitOne || hitTwo);
        if (setup && !pwrite && hitOne) begin
            nxt_st.prdata = {24'h000000, rdOne};
        end else if (setup && !pwrite && hitTwo) begin
            nxt_st.prdata = {24'h000000, rdTwo};
        end else if (setup) begin
            nxt_st.prdata = scfg_pkg::RST_PRDATA;
        end

        // Hardware clears come first so that a same-cycle write wins
        if (randomDone) begin
            nxt_st.randStart = 1'h0;
        end
        if (watchdogDone) begin
            nxt_st.wdRestart = 1'h0;
        end
        if (swResetDone) begin
            nxt_st.swReset = 1'h0;
        end
        if (periodReadCorrupt) begin
            nxt_st.readValid = 1'h0;
        end
        if (periodApplied) begin
            nxt_st.initPend = 1'h0;
        end
        if (periodWritten) begin
            nxt_st.initPend = 1'h1;
        end

        // Software writes; reserved bits are dropped
        if (wrByte && hitOne) begin
            nxt_st.twoWire   = wd[scfg_pkg::C1_TWOWIRE];
            nxt_st.txEcho    = wd[scfg_pkg::C1_TXECHO];
            nxt_st.timerEn   = wd[scfg_pkg::C1_TIMEREN];
            if (wd[scfg_pkg::C1_READVALID]) begin
                nxt_st.readValid = 1'h1;
            end else begin
                nxt_st.readValid = 1'h0;
            end
            if (wd[scfg_pkg::C1_RANDOM]) begin
                nxt_st.randStart = 1'h1;
            end
        end
        if (wrByte && hitTwo) begin
            nxt_st.genCall = wd[scfg_pkg::C2_GENCALL];
            nxt_st.ramOff  = wd[scfg_pkg::C2_RAMOFF];
            if (wd[scfg_pkg::C2_WDRESTART]) begin
                nxt_st.wdRestart = 1'h1;
            end
            if (wd[scfg_pkg::C2_SWRESET]) begin
                nxt_st.swReset = 1'h1;
            end
        end

        // Wakeup keeps echo, timer enable and RAM power only
        if (wakeupPulse) begin
            nxt_st.twoWire   = 1'h0;
            nxt_st.randStart = 1'h0;
            nxt_st.readValid = 1'h0;
            // A period write in the same cycle still wins over wakeup
            nxt_st.initPend  = periodWritten;
            nxt_st.genCall   = 1'h0;
            nxt_st.wdRestart = 1'h0;
            nxt_st.swReset   = 1'h0;
        end

        // Derived controls, registered so outputs come from flops
        nxt_st.timerRun =
            (scfg_pkg::scfg_mode_e'(opMode) == scfg_pkg::SCFG_MODE_NORMAL)
            || nxt_st.timerEn;
        nxt_st.paAuto = !nxt_st.txEcho;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff           <= '0;
            st_ff.ramOff    <= scfg_pkg::RST_RAMOFF;
            st_ff.twoWire   <= scfg_pkg::RST_CONFIG_ONE[scfg_pkg::C1_TWOWIRE];
            st_ff.txEcho    <= scfg_pkg::RST_CONFIG_ONE[scfg_pkg::C1_TXECHO];
            st_ff.timerEn   <= scfg_pkg::RST_CONFIG_ONE[scfg_pkg::C1_TIMEREN];
            st_ff.genCall   <= scfg_pkg::RST_CONFIG_TWO[scfg_pkg::C2_GENCALL];
            st_ff.paAuto    <= 1'h1;
            st_ff.timerRun  <= 1'h0;
            st_ff.prdata    <= scfg_pkg::RST_PRDATA;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready             = st_ff.pready;
    assign prdata             = st_ff.prdata;
    assign pslverr            = st_ff.pslverr;
    assign randomStart        = st_ff.randStart;
    assign watchdogRestart    = st_ff.wdRestart;
    assign swResetRequest     = st_ff.swReset;
    assign timerRun           = st_ff.timerRun;
    // Echo mode relies on software turning the amplifier on itself
    assign powerAmpAutoEnable = st_ff.paAuto;
    assign generalCallEnable  = st_ff.genCall;
    assign lowerRamPowerOff   = st_ff.ramOff;
    assign twowirePinSelect   = st_ff.twoWire;
    assign txEchoEnable       = st_ff.txEcho;

    // ------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------
    scfg_pin_mux u_pin_mux (
        .clk              (clk),
        .sys_rst          (sys_rst),
        .twowirePinSelect (st_ff.twoWire),
        .txEchoEnable     (st_ff.txEcho),
        .gpioDrive        (gpioDrive),
        .twiDrive         (twiDrive),
        .txData           (txData),
        .pinIn            (pinIn),
        .pinDrive         (pinDrive),
        .gpioIn           (gpioIn),
        .twiSclIn         (twiSclIn),
        .twiSdaIn         (twiSdaIn)
    );

endmodule // scfg_regs

/* File: scfg_regs_chk.sv */
// Purpose: Concurrent checks on the configuration register block ports
// Assumes: One clock domain, sys_rst asynchronous and active high
// Notes:   Write strobes rebuilt from the APB pins, not from internals
`timescale 1ns/10ps

module scfg_regs_chk (
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [3:0]           pstrb,
    input wire logic                 pready,
    input wire logic [31:0]          prdata,
    input wire logic                 pslverr,
    input wire logic                 wakeupPulse,
    input wire logic [1:0]           opMode,
    input wire logic                 randomDone,
    input wire logic                 randomStart,
    input wire logic                 watchdogRestart,
    input wire logic                 swResetRequest,
    input wire logic                 timerRun,
    input wire logic                 powerAmpAutoEnable,
    input wire logic                 generalCallEnable,
    input wire logic                 twowirePinSelect,
    input wire logic                 txEchoEnable,
    input wire scfg_pkg::scfg_twi_s  twiDrive,
    input wire logic                 txData,
    input wire scfg_pkg::scfg_pins_s pinDrive
);
    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    logic wrAny;
    logic wrOne;
    logic wrTwo;
    assign wrAny = psel && penable && pready && pwrite && pstrb[0];
    assign wrOne = wrAny && (paddr == scfg_pkg::OFF_CONFIG_ONE);
    assign wrTwo = wrAny && (paddr == scfg_pkg::OFF_CONFIG_TWO);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence setupPhase;
        psel && !penable;
    endsequence
    sequence swWrite;
        wrTwo && pwdata[0] && !wakeupPulse;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_ready_next: assert property (setupPhase |=> pready)
        else $error("pready missing after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_upper_zero: assert property
        (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_twowire_bit: assert property
        (wrOne && !wakeupPulse |=> twowirePinSelect == $past(pwdata[6]))
        else $error("two-wire select not written");
    chk_gencall_bit: assert property
        (wrTwo && !wakeupPulse |=> generalCallEnable == $past(pwdata[6]))
        else $error("general call enable not written");
    chk_random_done: assert property
        (randomDone && !(wrOne && pwdata[5]) |=> !randomStart)
        else $error("random start not cleared");
    chk_random_hold: assert property
        (randomStart && !randomDone && !wakeupPulse |=> randomStart)
        else $error("random start dropped early");
    chk_wdog_set: assert property
        (wrTwo && pwdata[1] && !wakeupPulse |=> watchdogRestart)
        else $error("watchdog restart not set");
    chk_swreset_set: assert property (swWrite |=> swResetRequest)
        else $error("software reset not requested");
    chk_timer_normal: assert property
        (opMode == scfg_pkg::SCFG_MODE_NORMAL |=> timerRun)
        else $error("timer stopped in normal mode");
    chk_pa_auto: assert property
        (powerAmpAutoEnable != txEchoEnable)
        else $error("auto amplifier enable wrong");
    chk_echo_pin: assert property
        (txEchoEnable |=> pinDrive.out[2] == $past(txData) && !pinDrive.oeN[2])
        else $error("echo pin not driven");
    chk_scl_route: assert property
        (twowirePinSelect |=> pinDrive.out[0] == $past(twiDrive.sclOut)
            && pinDrive.oeN[0] == $past(twiDrive.sclOeN))
        else $error("clock pin not routed");
endmodule // scfg_regs_chk

bind scfg_regs scfg_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .wakeupPulse(wakeupPulse), .opMode(opMode),
    .randomDone(randomDone), .randomStart(randomStart),
    .watchdogRestart(watchdogRestart), .swResetRequest(swResetRequest),
    .timerRun(timerRun), .powerAmpAutoEnable(powerAmpAutoEnable),
    .generalCallEnable(generalCallEnable),
    .twowirePinSelect(twowirePinSelect), .txEchoEnable(txEchoEnable),
    .twiDrive(twiDrive), .txData(txData), .pinDrive(pinDrive));

/* File: system_config_regs_tb.sv */
// Purpose: Directed scenarios for the configuration register block
// Assumes: APB slave answers within a few cycles of setup
// Notes:   ev packs the system pulses: wake,rnd,wdog,swr,pw,pa,corrupt
`timescale 1ns/10ps

module system_config_regs_tb;
    logic                 clk, sys_rst, psel, penable, pwrite, pready;
    logic                 pslverr, txData, er, randomStart, watchdogRestart;
    logic                 swResetRequest, timerRun, paAuto, genCall, ramOff;
    logic                 twoSel, txEcho, twiSclIn, twiSdaIn;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [3:0]           pstrb;
    logic [6:0]           ev;
    logic [1:0]           opMode;
    logic [2:0]           pinIn, gpioIn;
    scfg_pkg::scfg_pins_s gpioDrive, pinDrive;
    scfg_pkg::scfg_twi_s  twiDrive;
    int                   failures, comparisons;
    localparam logic [11:0] ONE = scfg_pkg::OFF_CONFIG_ONE;
    localparam logic [11:0] TWO = scfg_pkg::OFF_CONFIG_TWO;

    scfg_regs u_scfg_regs (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .wakeupPulse(ev[0]), .opMode(opMode), .randomDone(ev[1]),
        .watchdogDone(ev[2]), .swResetDone(ev[3]), .periodWritten(ev[4]),
        .periodApplied(ev[5]), .periodReadCorrupt(ev[6]),
        .randomStart(randomStart), .watchdogRestart(watchdogRestart),
        .swResetRequest(swResetRequest), .timerRun(timerRun),
        .powerAmpAutoEnable(paAuto), .generalCallEnable(genCall),
        .lowerRamPowerOff(ramOff), .twowirePinSelect(twoSel),
        .txEchoEnable(txEcho), .gpioDrive(gpioDrive), .twiDrive(twiDrive),
        .txData(txData), .pinIn(pinIn), .pinDrive(pinDrive),
        .gpioIn(gpioIn), .twiSclIn(twiSclIn), .twiSdaIn(twiSdaIn));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    always #12.5 clk = ~clk;

    task cmp(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits as long as it takes; a dead slave is left to the watchdog
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1);
        cmp("waits", 32'h1, n);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task rd_chk(input string what, input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        cmp(what, e, rd);
    endtask

    task pulse(input logic [6:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= 7'h00;
    endtask

    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd_chk("one", ONE, 32'h00);
        rd_chk("two", TWO, 32'h18);
        cmp("ramOff", 32'h1, {31'h0, ramOff});
        $display("test reset done");
    endtask

    task t_write_all;
        apb(1'h1, ONE, 32'hffff_ff77);
        apb(1'h1, TWO, 32'hffff_ffff);
        rd_chk("one", ONE, 32'h75);
        rd_chk("two", TWO, 32'h5b);
        settle;
        cmp("outs", 32'h77, {25'h0, twoSel, genCall, txEcho, paAuto,
            randomStart, watchdogRestart, swResetRequest});
        apb(1'h1, ONE, 32'h00);
        rd_chk("one", ONE, 32'h20);
        pulse(7'h0e);
        rd_chk("one", ONE, 32'h00);
        rd_chk("two", TWO, 32'h58);
        $display("test write and commands done");
    endtask

    task t_timer;
        pulse(7'h10);
        apb(1'h1, ONE, 32'h06);
        rd_chk("one", ONE, 32'h06);
        pulse(7'h20);
        rd_chk("one", ONE, 32'h04);
        pulse(7'h40);
        rd_chk("one", ONE, 32'h00);
        @(posedge clk) opMode <= scfg_pkg::SCFG_MODE_TEST;
        apb(1'h1, ONE, 32'h01);
        settle;
        cmp("run", 32'h1, {31'h0, timerRun});
        apb(1'h1, ONE, 32'h00);
        settle;
        cmp("run", 32'h0, {31'h0, timerRun});
        @(posedge clk) opMode <= scfg_pkg::SCFG_MODE_NORMAL;
        settle;
        cmp("run", 32'h1, {31'h0, timerRun});
        $display("test timer done");
    endtask

    task t_wake_pins;
        apb(1'h1, ONE, 32'h75);
        apb(1'h1, TWO, 32'h4b);
        pulse(7'h01);
        rd_chk("one", ONE, 32'h11);
        rd_chk("two", TWO, 32'h08);
        apb(1'h1, ONE, 32'h50);
        twiDrive <= 4'b1010;
        txData <= 1'h1;
        pinIn <= 3'h6;
        settle;
        cmp("pins", 32'h38, {26'h0, pinDrive});
        cmp("twiIn", 32'h1, {30'h0, twiSclIn, twiSdaIn});
        cmp("gpioIn", 32'h6, {29'h0, gpioIn});
        cmp("paAuto", 32'h0, {31'h0, paAuto});
        @(posedge clk);
        twiDrive <= 4'b0101;
        txData <= 1'h0;
        settle;
        cmp("pins", 32'h03, {26'h0, pinDrive});
        apb(1'h1, ONE, 32'h00);
        settle;
        cmp("pins", 32'h2a, {26'h0, pinDrive});
        cmp("twiIn", 32'h3, {30'h0, twiSclIn, twiSdaIn});
        $display("test wakeup and pins done");
    endtask

    task t_refuse;
        apb(1'h0, 12'h0e0, 32'h0);
        cmp("err", 32'h1, {31'h0, er});
        cmp("data", 32'h0, rd);
        pstrb <= 4'h0;
        apb(1'h1, TWO, 32'h48);
        pstrb <= 4'hf;
        rd_chk("two", TWO, 32'h08);
        $display("test refusal done");
    endtask

    task wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk = 1'h0;
        sys_rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        ev = 7'h00;
        opMode = scfg_pkg::SCFG_MODE_DEBUG;
        txData = 1'h0;
        pinIn = 3'h5;
        gpioDrive = 6'h2a;
        twiDrive = 4'h0;
        failures = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        t_reset;
        t_write_all;
        t_timer;
        t_wake_pins;
        t_refuse;
        // Mid-run reset must bring the reset values back
        @(posedge clk) sys_rst <= 1'h1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        t_reset;
        wrap_up;
    end

    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        wrap_up;
    end
endmodule // system_config_regs_tb
